// *** acc_pkg.sv ***
// Package of register offsets, field positions and timing for the converter control block.
package acc_pkg;

   // ------------------------------
   // Register offsets (byte addresses on the plain register port).
   // ------------------------------
   localparam logic [8:0] ACC_CTL0_OFS   = 9'h1a0;
   localparam logic [8:0] ACC_CTL1_OFS   = 9'h1a2;
   localparam logic [8:0] ACC_VEC_OFS    = 9'h1a8;
   localparam logic [8:0] ACC_RES_BASE   = 9'h140;
   localparam logic [8:0] ACC_SLOT_BASE  = 9'h080;
   localparam logic [8:0] ACC_FLAG_OFS   = 9'h1a4;
   localparam logic [8:0] ACC_IEN_OFS    = 9'h1a6;

   // ------------------------------
   // Field positions in control word 0.
   // ------------------------------
   localparam int ACC_B_SOFT_START = 0;
   localparam int ACC_B_CONV_EN    = 1;
   localparam int ACC_B_TOV_IE     = 2;
   localparam int ACC_B_OV_IE      = 3;
   localparam int ACC_B_CORE_PWR   = 4;
   localparam int ACC_B_REF_PWR    = 5;
   localparam int ACC_B_REF_LVL    = 6;
   localparam int ACC_B_MULTI      = 7;
   localparam int ACC_B_SHT_LO     = 8;
   localparam int ACC_B_SHT_HI     = 12;

   // ------------------------------
   // Field positions in control word 1.
   // ------------------------------
   localparam int ACC_B_ACTIVE     = 0;
   localparam int ACC_B_MODE       = 1;
   localparam int ACC_B_CLKSEL     = 3;
   localparam int ACC_B_DIV        = 5;
   localparam int ACC_B_INV        = 8;
   localparam int ACC_B_PULSE      = 9;
   localparam int ACC_B_TRIG       = 10;
   localparam int ACC_B_FIRST      = 12;

   // Bits that stay writable while conversion is enabled.
   localparam logic [15:0] ACC_CTL0_FREE = 16'h000f;
   localparam logic [15:0] ACC_CTL1_FREE = 16'h0006;

   // ------------------------------
   // Reset values and timing.
   // ------------------------------
   localparam logic [15:0] ACC_CTL_RST   = 16'h0000;
   localparam int          ACC_CONV_CLKS = 13;
   localparam int          ACC_SAMPLE_MUL = 4;
   localparam logic [15:0] ACC_VEC_OV    = 16'h0002;
   localparam logic [15:0] ACC_VEC_TOV   = 16'h0004;
   localparam logic [15:0] ACC_VEC_FLAG0 = 16'h0006;

   // Converter states.
   typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT} acc_state_t;

endpackage

// *** acc_core.sv ***
// Converter control, sequencing, result slots and event vector logic.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Control bits clear; all but the free bits locked while enabled
// - Slot control writes ignored while enabled
// - Pulse mode: start edge converts, autoclears
// - Extended mode: sample while start high
// - Conversions start only while enable is set
// - Start during sample or conversion raises timing overflow
// - Unread result overwritten raises overflow
// - Core power off blocks conversion
// - Reference power and level outputs
// - Multi-conv chains conversions after trigger
// - Sample time four clocks times n
// - Low field slots 0-7, high 8-15
// - Active bit reflects sample, conversion or unfinished run
// - Mode field: single, sequence, repeats
// - Clock source select field
// - Divider value plus one, 13 clocks
// - Invert trigger; pulse selects sample timer
// - Trigger source select
// - First slot selects start pair
// - Sixteen slot controls paired with results
// - Flags and enables, flag 0 first
// - Vector word reports top pending event
module acc_core
   import acc_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Register port.
   input  wire logic [8:0]  addr_i,
   input  wire logic [15:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [15:0] rdata_o,
   // Clock sources and timer triggers (asynchronous pins).
   input  wire logic [3:0]  clk_src_i,
   input  wire logic [2:0]  timer_trig_i,
   // Analog core side.
   input  wire logic [11:0] sample_data_i,
   output logic             core_power_o,
   output logic             ref_power_o,
   output logic             ref_level_sel_o,
   output logic             sample_o,
   output logic      [7:0]  slot_control_o,
   output logic             irq_o
);

   // ------------------------------
   // Registers.
   // ------------------------------
   logic [15:0] ctl0_q;                 // Control word 0.
   logic [15:0] ctl1_q;                 // Control word 1 without active.
   logic [7:0]  slot_q [16];            // Slot control registers.
   logic [15:0] res_q  [16];            // Result slots.
   logic [15:0] flag_q;                 // Result flags.
   logic [15:0] ien_q;                  // Result enables.
   logic [15:0] unread_q;               // Result not yet read.
   logic        ov_q;                   // Overflow event.
   logic        tov_q;                  // Timing overflow event.
   acc_state_t  state_q;                // Converter state.
   logic [3:0]  slot_idx_q;             // Slot in use.
   logic [10:0] cnt_q;                  // Converter clock counter.
   logic        run_q;                  // A run is in progress.
   logic        trig_d1_q;              // Trigger pipeline.
   logic [3:0]  src_s1_q, src_s2_q, src_s3_q; // Clock source sync.
   logic [2:0]  tmr_s1_q, tmr_s2_q;     // Timer trigger sync.
   logic [2:0]  div_q;                  // Divider counter.
   logic        cclk_tick;              // One converter clock tick.

   // Named control fields.
   logic        soft_start, conv_enable, multi_conv, pulse_sample_mode;
   logic [1:0]  conv_mode, clock_source_sel, trigger_source_sel;
   logic [2:0]  clock_divider;
   logic        conv_active, trig, trig_rise, trig_fall;

   assign soft_start         = ctl0_q[ACC_B_SOFT_START];
   assign conv_enable        = ctl0_q[ACC_B_CONV_EN];
   assign multi_conv         = ctl0_q[ACC_B_MULTI];
   assign conv_mode          = ctl1_q[ACC_B_MODE +: 2];
   assign clock_source_sel   = ctl1_q[ACC_B_CLKSEL +: 2];
   assign clock_divider      = ctl1_q[ACC_B_DIV +: 3];
   assign pulse_sample_mode  = ctl1_q[ACC_B_PULSE];
   assign trigger_source_sel = ctl1_q[ACC_B_TRIG +: 2];
   assign conv_active        = (state_q != ACC_IDLE) || run_q;

   // ------------------------------
   // Synchronisers for pins from other domains.
   // ------------------------------
   // Source clocks are sampled, so they must run well below 100 MHz.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         src_s1_q <= 4'h0;
         src_s2_q <= 4'h0;
         src_s3_q <= 4'h0;
         tmr_s1_q <= 3'h0;
         tmr_s2_q <= 3'h0;
      end else begin
         src_s1_q <= clk_src_i;
         src_s2_q <= src_s1_q;
         src_s3_q <= src_s2_q;
         tmr_s1_q <= timer_trig_i;
         tmr_s2_q <= tmr_s1_q;
      end
   end

   // ------------------------------
   // Converter clock: rising edge of chosen source, divided.
   // ------------------------------
   logic src_edge;
   assign src_edge = src_s2_q[clock_source_sel] &
                     ~src_s3_q[clock_source_sel];

   // Counts source edges and emits one tick per value-plus-one edges.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         div_q <= 3'h0;
      end else if (src_edge) begin
         div_q <= (div_q >= clock_divider) ? 3'h0 : div_q + 3'h1;
      end
   end
   assign cclk_tick = src_edge && (div_q >= clock_divider);

   // ------------------------------
   // Trigger selection and edges.
   // ------------------------------
   always_comb begin
      unique case (trigger_source_sel)
         2'd0: trig = soft_start;
         2'd1: trig = tmr_s2_q[0];
         2'd2: trig = tmr_s2_q[1];
         2'd3: trig = tmr_s2_q[2];
      endcase
      trig = trig ^ ctl1_q[ACC_B_INV];
   end
   assign trig_rise = trig & ~trig_d1_q;
   assign trig_fall = ~trig & trig_d1_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trig_d1_q <= 1'b0;
      end else begin
         trig_d1_q <= trig;
      end
   end

   // ------------------------------
   // Sample length in converter clocks.
   // ------------------------------
   function automatic logic [10:0] sample_clks(input logic [3:0] code);
      logic [8:0] n;
      unique case (code)
         4'd0:  n = 9'd1;
         4'd1:  n = 9'd2;
         4'd2:  n = 9'd4;
         4'd3:  n = 9'd8;
         4'd4:  n = 9'd16;
         4'd5:  n = 9'd24;
         4'd6:  n = 9'd32;
         4'd7:  n = 9'd48;
         4'd8:  n = 9'd64;
         4'd9:  n = 9'd96;
         4'd10: n = 9'd128;
         4'd11: n = 9'd192;
         default: n = 9'd256;
      endcase
      return 11'(n * ACC_SAMPLE_MUL);
   endfunction

   logic [3:0] sht_code;
   assign sht_code = slot_idx_q[3] ? ctl0_q[ACC_B_SHT_HI +: 4]
                                   : ctl0_q[ACC_B_SHT_LO +: 4];

   // ------------------------------
   // Conversion sequencer.
   // ------------------------------
   logic start_ok, conv_done, last_slot, chain, seq_mode;
   assign start_ok  = conv_enable && ctl0_q[ACC_B_CORE_PWR];
   assign conv_done = (state_q == ACC_CONVERT) && cclk_tick &&
                      (cnt_q == 11'(ACC_CONV_CLKS - 1));
   assign seq_mode  = conv_mode[0];
   assign last_slot = seq_mode ? slot_q[slot_idx_q][7] : 1'b1;
   assign chain     = multi_conv && pulse_sample_mode &&
                      (conv_mode != 2'd0);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_q    <= ACC_IDLE;
         cnt_q      <= 11'h000;
         slot_idx_q <= 4'h0;
         run_q      <= 1'b0;
      end else begin
         unique case (state_q)
            ACC_IDLE: begin
               if (run_q && chain && start_ok) begin
                  state_q <= ACC_SAMPLE;
                  cnt_q   <= 11'h000;
               end else if (trig_rise && start_ok) begin
                  state_q <= ACC_SAMPLE;
                  cnt_q   <= 11'h000;
                  run_q   <= 1'b1;
                  if (!run_q) begin
                     slot_idx_q <= ctl1_q[ACC_B_FIRST +: 4];
                  end
               end else if (!conv_enable) begin
                  run_q <= 1'b0;
               end
            end
            ACC_SAMPLE: begin
               if (pulse_sample_mode) begin
                  if (cclk_tick) begin
                     cnt_q <= cnt_q + 11'h001;
                  end
                  if (cclk_tick && cnt_q == sample_clks(sht_code) - 11'h001) begin
                     state_q <= ACC_CONVERT;
                     cnt_q   <= 11'h000;
                  end
               end else if (trig_fall) begin
                  state_q <= ACC_CONVERT;
                  cnt_q   <= 11'h000;
               end
            end
            ACC_CONVERT: begin
               if (cclk_tick) begin
                  cnt_q <= cnt_q + 11'h001;
               end
               if (conv_done) begin
                  state_q <= ACC_IDLE;
                  if (last_slot && !conv_mode[1]) begin
                     run_q <= 1'b0;
                  end
                  if (seq_mode) begin
                     slot_idx_q <= last_slot ? ctl1_q[ACC_B_FIRST +: 4]
                                             : slot_idx_q + 4'h1;
                  end
               end
            end
            default: state_q <= ACC_IDLE;
         endcase
      end
   end

   // ------------------------------
   // Register decode.
   // ------------------------------
   logic [15:0] vec_d;                  // Vector word value.
   logic [3:0]  vec_idx;                // Flag that the vector reports.
   logic        vec_rd;                 // Vector word read strobe.
   logic [15:0] pend;                   // Enabled pending flags.
   logic wr_ctl0, wr_ctl1, wr_flag, wr_ien, res_rd, slot_wr;
   logic [3:0] aidx;
   assign wr_ctl0 = wr_i && addr_i == ACC_CTL0_OFS;
   assign wr_ctl1 = wr_i && addr_i == ACC_CTL1_OFS;
   assign wr_flag = wr_i && addr_i == ACC_FLAG_OFS;
   assign wr_ien  = wr_i && addr_i == ACC_IEN_OFS;
   assign aidx    = addr_i[4:1];
   assign res_rd  = rd_i && addr_i[8:5] == ACC_RES_BASE[8:5] && !addr_i[0];
   assign slot_wr = wr_i && addr_i[8:4] == ACC_SLOT_BASE[8:4];

   // Control words; locked bits keep their value while enabled.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctl0_q <= ACC_CTL_RST;
         ctl1_q <= ACC_CTL_RST;
      end else begin
         if (wr_ctl0) begin
            ctl0_q <= conv_enable ? ((wdata_i & ACC_CTL0_FREE) |
                                     (ctl0_q & ~ACC_CTL0_FREE))
                                  : wdata_i;
         end else if (conv_done && pulse_sample_mode &&
                      (last_slot || !chain)) begin
            ctl0_q[ACC_B_SOFT_START] <= 1'b0;
         end
         if (wr_ctl1) begin
            ctl1_q <= (conv_enable ? ((wdata_i & ACC_CTL1_FREE) |
                                      (ctl1_q & ~ACC_CTL1_FREE))
                                   : wdata_i) & 16'hfffe;
         end
      end
   end

   // Slot control registers, writable only while disabled.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 16; i++) slot_q[i] <= 8'h00;
      end else if (slot_wr && !conv_enable) begin
         slot_q[addr_i[3:0]] <= wdata_i[7:0];
      end
   end

   // Results, flags and overflow events; set wins over clear.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < 16; i++) res_q[i] <= 16'h0000;
         flag_q   <= 16'h0000;
         ien_q    <= 16'h0000;
         unread_q <= 16'h0000;
         ov_q     <= 1'b0;
         tov_q    <= 1'b0;
      end else begin
         if (wr_ien) ien_q <= wdata_i;
         if (wr_flag) flag_q <= wdata_i;
         if (res_rd) begin
            unread_q[aidx] <= 1'b0;
            flag_q[aidx]   <= 1'b0;
         end
         if (vec_rd && vec_d == ACC_VEC_OV) ov_q <= 1'b0;
         if (vec_rd && vec_d == ACC_VEC_TOV) tov_q <= 1'b0;
         if (vec_rd && vec_d >= ACC_VEC_FLAG0) begin
            flag_q[4'(vec_idx)] <= 1'b0;
         end
         if (conv_done) begin
            res_q[slot_idx_q]    <= {4'h0, sample_data_i};
            flag_q[slot_idx_q]   <= 1'b1;
            unread_q[slot_idx_q] <= 1'b1;
            if (unread_q[slot_idx_q]) ov_q <= 1'b1;
         end
         if (trig_rise && start_ok && state_q != ACC_IDLE) begin
            tov_q <= 1'b1;
         end
      end
   end

   // ------------------------------
   // Vector word: overflow, timing overflow, then flags 0..15.
   // ------------------------------
   assign vec_rd = rd_i && addr_i == ACC_VEC_OFS;
   assign pend   = flag_q & ien_q;
   always_comb begin
      vec_d   = 16'h0000;
      vec_idx = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (pend[i]) begin
            vec_idx = 4'(i);
            vec_d   = ACC_VEC_FLAG0 + 16'(2 * i);
         end
      end
      if (tov_q && ctl0_q[ACC_B_TOV_IE]) vec_d = ACC_VEC_TOV;
      if (ov_q && ctl0_q[ACC_B_OV_IE]) vec_d = ACC_VEC_OV;
   end

   // ------------------------------
   // Read data, one cycle after the strobe.
   // ------------------------------
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         if (addr_i == ACC_CTL0_OFS)      rdata_o <= ctl0_q;
         else if (addr_i == ACC_CTL1_OFS) rdata_o <= ctl1_q | 16'(conv_active);
         else if (vec_rd)                 rdata_o <= vec_d;
         else if (addr_i == ACC_FLAG_OFS) rdata_o <= flag_q;
         else if (addr_i == ACC_IEN_OFS)  rdata_o <= ien_q;
         else if (res_rd)                 rdata_o <= res_q[aidx];
         else if (addr_i[8:4] == ACC_SLOT_BASE[8:4])
            rdata_o <= {8'h00, slot_q[addr_i[3:0]]};
         else rdata_o <= 16'h0000;
      end else begin
         rdata_o <= 16'h0000;
      end
   end

   // Outputs to the analog side.
   assign core_power_o    = ctl0_q[ACC_B_CORE_PWR];
   assign ref_power_o     = ctl0_q[ACC_B_REF_PWR];
   assign ref_level_sel_o = ctl0_q[ACC_B_REF_PWR] & ctl0_q[ACC_B_REF_LVL];
   assign sample_o        = (state_q == ACC_SAMPLE);
   assign slot_control_o  = slot_q[slot_idx_q];
   assign irq_o           = |vec_d;

endmodule // acc_core

`default_nettype wire

// *** acc_core_sva.sv ***
// Checker of the register port and converter outputs.
`timescale 1ns/1ps
`default_nettype none
module acc_core_chk
   import acc_pkg::*;
(
   // Clock and reset.
   input wire logic        clk_i,
   input wire logic        rstn_i,
   // Register port.
   input wire logic [8:0]  addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [15:0] rdata_o,
   // Converter side.
   input wire logic        core_power_o,
   input wire logic        ref_power_o,
   input wire logic        ref_level_sel_o,
   input wire logic        sample_o,
   input wire logic        irq_o
);
   // ------------------------------
   // Shadow state.
   // ------------------------------
   logic      en_q;  // Enable is always writable, so this is exact.
   logic      p_q;   // Pulse mode bit, written only while disabled.
   wire logic w0 = wr_i && addr_i == ACC_CTL0_OFS;
   wire logic rv = rd_i && addr_i == ACC_VEC_OFS;

   // Track enable and pulse mode from the writes themselves.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en_q <= 1'b0;
         p_q  <= 1'b0;
      end else begin
         if (w0) en_q <= wdata_i[ACC_B_CONV_EN];
         if (wr_i && addr_i == ACC_CTL1_OFS && !en_q) begin
            p_q <= wdata_i[ACC_B_PULSE];
         end
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_power_follow: assert property (
      w0 && !en_q |=> core_power_o == $past(wdata_i[4])
      && ref_power_o == $past(wdata_i[5])
      && ref_level_sel_o == ($past(wdata_i[5]) && $past(wdata_i[6])))
      else $error("power outputs do not follow write");
   a_power_locked: assert property (
      w0 && en_q |=> $stable(core_power_o) && $stable(ref_power_o)
      && $stable(ref_level_sel_o))
      else $error("locked bits changed");
   a_start_gate: assert property (
      $rose(sample_o) |-> $past(en_q) && $past(core_power_o))
      else $error("sample began without enable or power");
   a_sample_min: assert property (
      $rose(sample_o) && p_q |-> sample_o [*8])
      else $error("pulse sample too short");
   a_busy_sample: assert property (
      rd_i && addr_i == ACC_CTL1_OFS && sample_o |=> rdata_o[0])
      else $error("busy low while sampling");
   a_irq_vector: assert property (
      rv |=> (rdata_o != 16'h0000) == $past(irq_o))
      else $error("irq disagrees with vector");
   a_vec_even: assert property (
      rv |=> !rdata_o[0] && rdata_o <= 16'h0024)
      else $error("vector odd or out of range");
   a_rdata_idle: assert property (
      !rd_i |=> rdata_o == 16'h0000)
      else $error("read data without read");

   c_sample: cover property ($rose(sample_o));
   c_irq: cover property ($rose(irq_o));
   c_locked: cover property (w0 && en_q);
endmodule // acc_core_chk

bind acc_core acc_core_chk i_acc_core_chk (.clk_i(clk_i), .rstn_i(rstn_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .core_power_o(core_power_o),
   .ref_power_o(ref_power_o), .ref_level_sel_o(ref_level_sel_o),
   .sample_o(sample_o), .irq_o(irq_o));
`default_nettype wire

// *** acc_core_bench.sv ***
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module acc_core_bench
   import acc_pkg::*;
;
   // ------------------------------
   // Signals and bench state.
   // ------------------------------
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [8:0]  addr_i = 9'h000;
   logic [15:0] wdata_i = 16'h0000;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [3:0]  clk_src_i = 4'h0;
   logic [2:0]  timer_trig_i = 3'h0;
   logic [11:0] sample_data_i = 12'h000;
   logic [15:0] rdata_o;
   logic [7:0]  slot_control_o;
   logic        core_power_o, ref_power_o, ref_level_sel_o;
   logic        sample_o, irq_o;
   int          seed = 21204;  // Fixed so runs repeat.
   int          n_fail = 0;
   int          compares = 0;
   int          cyc = 0;
   logic [15:0] d;             // Last read value.
   int          nt [16] = '{1, 2, 4, 8, 16, 24, 32, 48, 64, 96, 128,
                            192, 256, 256, 256, 256};
   // Codes chosen so codes c and b run on the 4-cycle tick and code f on a 16-cycle tick.
   logic [3:0]  cds [6] = '{4'hc, 4'h0, 4'h5, 4'h1, 4'hb, 4'hf};
   logic [8:0]  ra [7] = '{ACC_CTL0_OFS, ACC_CTL1_OFS, ACC_FLAG_OFS,
                           ACC_IEN_OFS, ACC_VEC_OFS, ACC_RES_BASE,
                           ACC_SLOT_BASE};

   always #2.5 clk_i = ~clk_i;

   // Source clocks of periods 4, 8, 12 and 16 cycles.
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      clk_src_i <= {cyc % 16 < 8, cyc % 12 < 6, cyc % 8 < 4, cyc % 4 < 2};
   end

   acc_core i_acc_core (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .clk_src_i(clk_src_i), .timer_trig_i(timer_trig_i),
      .sample_data_i(sample_data_i), .core_power_o(core_power_o),
      .ref_power_o(ref_power_o), .ref_level_sel_o(ref_level_sel_o),
      .sample_o(sample_o), .slot_control_o(slot_control_o),
      .irq_o(irq_o));

   // ------------------------------
   // Bus, compare and wait tasks.
   // ------------------------------
   task automatic wr16(input logic [8:0] a, input logic [15:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd16(input logic [8:0] a, output logic [15:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      v = rdata_o;
   endtask

   task automatic chk(input string n, input logic [15:0] e,
                      input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask

   // Tick phase is unknown at start, so one tick of slack.
   task automatic chkt(input string n, input int e, input int g,
                       input int t);
      compares++;
      if (g < e - t || g > e + t) begin
         n_fail++;
         $display("CHECK FAILED %s exp %0d got %0d", n, e, g);
      end
   endtask

   task automatic rchk(input string n, input logic [8:0] a,
                       input logic [15:0] e);
      rd16(a, d);
      chk(n, e, d);
   endtask

   // Waits for a sample to begin, then counts its length.
   task automatic meas(output int len);
      int k;
      len = 0;
      for (k = 0; k < 200 && sample_o !== 1'b1; k++) @(negedge clk_i);
      while (sample_o === 1'b1 && len < 20000) begin
         @(negedge clk_i);
         len++;
      end
   endtask

   // Polls the active bit until the converter is idle.
   task automatic idle();
      int k;
      for (k = 0; k < 400; k++) begin
         rd16(ACC_CTL1_OFS, d);
         if (d[0] === 1'b0) break;
      end
      chk("idle", 16'h0000, {15'h0000, d[0]});
   endtask

   task automatic quiet(input string n);
      int k;
      int h;
      h = 0;
      for (k = 0; k < 40; k++) begin
         @(negedge clk_i);
         if (sample_o !== 1'b0) h++;
      end
      chk(n, 16'h0000, 16'(h));
   endtask

   task automatic pulse(input int b);
      @(posedge clk_i);
      timer_trig_i <= 3'(1 << b);
      repeat (6) @(posedge clk_i);
      timer_trig_i <= 3'h0;
   endtask

   task automatic end_sim();
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (60000) @(posedge clk_i);
      n_fail++;
      end_sim();
   end

   // ------------------------------
   // Main sequence.
   // ------------------------------
   initial begin
      int          i;
      int          len;
      int          p;
      logic [3:0]  sl;
      logic [11:0] sdv;
      logic [15:0] w;
      logic [7:0]  sv [16];
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      foreach (ra[k]) rchk("reset", ra[k], 16'h0000);
      rchk("unmapped", 9'h1fe, 16'h0000);
      // Field storage while disabled.
      for (i = 0; i < 4; i++) begin
         w = 16'($random(seed)) & 16'hfffc;
         wr16(ACC_CTL0_OFS, w);
         rchk("ctl0", ACC_CTL0_OFS, w);
         w = 16'($random(seed)) & 16'hfffe;
         wr16(ACC_CTL1_OFS, w);
         rchk("ctl1", ACC_CTL1_OFS, w);
      end
      for (i = 0; i < 16; i++) begin
         sv[i] = 8'($random(seed));
         wr16(ACC_SLOT_BASE + 9'(i), {8'h00, sv[i]});
      end
      for (i = 0; i < 16; i++)
         rchk("slot", ACC_SLOT_BASE + 9'(i), {8'h00, sv[i]});
      chk("slot out", {8'h00, sv[0]}, {8'h00, slot_control_o});
      // Locking while enabled, core still unpowered.
      wr16(ACC_CTL0_OFS, 16'h0002);
      wr16(ACC_SLOT_BASE, {8'h00, ~sv[0]});
      rchk("slot lock", ACC_SLOT_BASE, {8'h00, sv[0]});
      wr16(ACC_CTL0_OFS, 16'hfffe);
      rchk("ctl0 lock", ACC_CTL0_OFS, 16'h000e);
      wr16(ACC_CTL1_OFS, 16'hffff);
      rchk("ctl1 lock", ACC_CTL1_OFS, (w & 16'hfff8) | 16'h0006);
      wr16(ACC_CTL0_OFS, 16'h0000);
      wr16(ACC_CTL1_OFS, 16'h0200);
      wr16(ACC_CTL0_OFS, 16'h0003);
      quiet("power off");
      wr16(ACC_CTL0_OFS, 16'h0000);
      wr16(ACC_CTL0_OFS, 16'h0011);
      quiet("not enabled");
      wr16(ACC_IEN_OFS, 16'hffff);
      // Pulse conversions over codes, slots, sources and dividers.
      for (i = 0; i < 6; i++) begin
         wr16(ACC_CTL0_OFS, 16'h0000);
         sl = 4'($random(seed));
         sdv = 12'($random(seed));
         sample_data_i <= sdv;
         p = 4 * (i % 4 + 1) * (i % 2 + 1);
         wr16(ACC_CTL1_OFS, {sl, 4'b0010, 3'(i % 2), 2'(i % 4), 3'b000});
         w = sl[3] ? {cds[i], cds[i] ^ 4'h4, 8'h1f}
                   : {cds[i] ^ 4'h4, cds[i], 8'h1f};
         wr16(ACC_CTL0_OFS, w);
         meas(len);
         chkt("sample time", 4 * nt[cds[i]] * p, len, p);
         idle();
         rchk("start clear", ACC_CTL0_OFS, w & 16'hfffe);
         rchk("vector", ACC_VEC_OFS, 16'h0006 + 16'(2 * sl));
         rchk("result", ACC_RES_BASE + 9'(2 * sl), {4'h0, sdv});
      end
      // Extended sampling follows the inverted start bit.
      wr16(ACC_CTL0_OFS, 16'h0000);
      wr16(ACC_CTL1_OFS, 16'h0100);
      wr16(ACC_CTL0_OFS, 16'h0013);
      wr16(ACC_CTL0_OFS, 16'h0012);
      repeat (60) @(posedge clk_i);
      @(negedge clk_i);
      chk("ext sample", 16'h0001, {15'h0000, sample_o});
      rchk("ext busy", ACC_CTL1_OFS, 16'h0101);
      wr16(ACC_CTL0_OFS, 16'h0013);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      chk("ext end", 16'h0000, {15'h0000, sample_o});
      idle();
      rchk("ext vector", ACC_VEC_OFS, 16'h0006);
      rd16(ACC_RES_BASE, d);
      // Timer triggers, and a second trigger while converting.
      for (i = 1; i < 4; i++) begin
         wr16(ACC_CTL0_OFS, 16'h0000);
         wr16(ACC_CTL1_OFS, {4'h0, 2'(i), 10'h200});
         wr16(ACC_CTL0_OFS, 16'h221e);
         pulse(i % 3);
         quiet("wrong trigger");
         pulse(i - 1);
         @(negedge clk_i);
         chk("trig start", 16'h0001, {15'h0000, sample_o});
         meas(len);
         pulse(i - 1);
         idle();
         rchk("timing ovf", ACC_VEC_OFS, 16'h0004);
         rchk("flag vector", ACC_VEC_OFS, 16'h0006);
         rd16(ACC_RES_BASE, d);
      end
      // Two results into slot 5 with no read between.
      wr16(ACC_CTL0_OFS, 16'h0000);
      wr16(ACC_CTL1_OFS, 16'h5200);
      for (i = 0; i < 2; i++) begin
         wr16(ACC_CTL0_OFS, 16'h001e);
         wr16(ACC_CTL0_OFS, 16'h001f);
         meas(len);
         idle();
      end
      rchk("overflow", ACC_VEC_OFS, 16'h0002);
      rchk("ovf flag", ACC_VEC_OFS, 16'h0010);
      rchk("none", ACC_VEC_OFS, 16'h0000);
      rd16(ACC_RES_BASE + 9'h00a, d);
      // Sequence of slots 0 and 1 from a single start.
      wr16(ACC_CTL0_OFS, 16'h0000);
      wr16(ACC_SLOT_BASE, 16'h0000);
      wr16(ACC_SLOT_BASE + 9'h001, 16'h0080);
      wr16(ACC_CTL1_OFS, 16'h0202);
      wr16(ACC_CTL0_OFS, 16'h009f);
      meas(len);
      idle();
      rchk("sequence", ACC_FLAG_OFS, 16'h0003);
      end_sim();
   end
endmodule // acc_core_bench
`default_nettype wire
